// ---- hw/bsz_pkg.sv ----
package bsz_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BYTE_W = 8;

    // ************************************************************
    // width acknowledge codes {ack_hi_n, ack_lo_n}, active low
    // ************************************************************
    localparam logic [1:0] ACK_PORT32 = 2'h0;
    localparam logic [1:0] ACK_PORT16 = 2'h1;
    localparam logic [1:0] ACK_PORT8  = 2'h2;
    localparam logic [1:0] ACK_NONE   = 2'h3;
    localparam logic [1:0] ACK_RESET  = 2'h3;

    // ************************************************************
    // byte counts and size codes
    // ************************************************************
    localparam logic [2:0] CNT_ZERO  = 3'h0;
    localparam logic [2:0] CNT_ONE   = 3'h1;
    localparam logic [2:0] CNT_TWO   = 3'h2;
    localparam logic [2:0] CNT_FOUR  = 3'h4;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] OFF_ALIGN = 2'h0;

    typedef enum logic [1:0] {
        BSZ_IDLE,
        BSZ_ADDR,
        BSZ_DATA,
        BSZ_TERM
    } bsz_state_type;

    // size code 00 means four bytes, any other code is its own count
    function automatic logic [2:0] size_to_count(input logic [1:0] code);
        size_to_count = {code == SIZE_LONG, code};
    endfunction

    function automatic logic [2:0] port_bytes(input logic [1:0] ack_n);
        case (ack_n)
            ACK_PORT32: port_bytes = CNT_FOUR;
            ACK_PORT16: port_bytes = CNT_TWO;
            ACK_PORT8:  port_bytes = CNT_ONE;
            default:    port_bytes = CNT_ZERO;
        endcase
    endfunction

    // bytes one bus cycle can move: limited by port edge and remainder
    function automatic logic [2:0] bytes_taken(input logic [2:0] pw,
                                               input logic [1:0] off,
                                               input logic [2:0] rem);
        logic [2:0] room;
        room = CNT_ONE;
        if (pw == CNT_FOUR) begin
            room = CNT_FOUR - {1'b0, off};
        end else if (pw == CNT_TWO) begin
            room = CNT_TWO - {2'h0, off[0]};
        end
        bytes_taken = (rem < room) ? rem : room;
    endfunction

endpackage

// ---- hw/bsz_lane_steer.sv ----
module bsz_lane_steer (
    input  wire logic [1:0]                 off,        // low address bits
    input  wire logic [2:0]                 pw,         // port bytes
    input  wire logic [2:0]                 taken,      // bytes moved
    input  wire logic [bsz_pkg::DATA_W-1:0] rem_data,   // next byte on top
    input  wire logic [bsz_pkg::DATA_W-1:0] data_in,    // bus data
    output logic      [bsz_pkg::DATA_W-1:0] lane_wdata, // write lanes
    output logic      [bsz_pkg::DATA_W-1:0] rd_bytes    // read, right aligned
);

    import bsz_pkg::*;

    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [1:0] start;
    logic [DATA_W-1:0] aligned;

    // ************************************************************
    // write lanes: top lane always holds the next operand byte so
    // narrow ports on the upper lanes see the right byte
    // ************************************************************
    always_comb begin
        b0 = rem_data[31:24];
        b1 = rem_data[23:16];
        b2 = rem_data[15:8];
        b3 = rem_data[7:0];
        lane_wdata[31:24] = b0;
        lane_wdata[23:16] = off[0] ? b0 : b1;
        unique case (off)
            2'h0: lane_wdata[15:8] = b2;
            2'h1: lane_wdata[15:8] = b1;
            2'h2: lane_wdata[15:8] = b0;
            2'h3: lane_wdata[15:8] = b0;
        endcase
        unique case (off)
            2'h0: lane_wdata[7:0] = b3;
            2'h1: lane_wdata[7:0] = b2;
            2'h2: lane_wdata[7:0] = b1;
            2'h3: lane_wdata[7:0] = b0;
        endcase
    end

    // ************************************************************
    // read lanes: first valid lane depends on the port width
    // ************************************************************
    always_comb begin
        start = 2'h0;
        if (pw == CNT_FOUR) begin
            start = off;
        end else if (pw == CNT_TWO) begin
            start = {1'b0, off[0]};
        end
        aligned  = data_in << {start, 3'h0};
        rd_bytes = aligned >> {CNT_FOUR - taken, 3'h0};
    end

endmodule

// ---- hw/bsz_bus_sizer.sv ----
module bsz_bus_sizer (
    input  wire logic                       clk,                 // 20 MHz
    input  wire logic                       nrst,                // async, low
    input  wire logic                       req,                 // start pulse
    input  wire logic                       req_write,           // 1 write
    input  wire logic                       req_fetch,           // fetch
    input  wire logic [1:0]                 req_size,            // size code
    input  wire logic [bsz_pkg::ADDR_W-1:0] req_addr,            // op address
    input  wire logic [bsz_pkg::DATA_W-1:0] req_wdata,           // write op
    output logic                            busy,                // in transfer
    output logic                            done,                // end pulse
    output logic      [bsz_pkg::DATA_W-1:0] rdata,               // read op
    output logic      [bsz_pkg::ADDR_W-1:0] bus_addr,            // address
    output logic                            xfer_size_hi,        // size bit 1
    output logic                            xfer_size_lo,        // size bit 0
    output logic                            bus_read,            // 1 read
    output logic                            addr_valid_strobe_n, // addr strobe
    output logic                            data_valid_strobe_n, // data strobe
    output logic      [bsz_pkg::DATA_W-1:0] data_out,            // lanes out
    output logic                            data_oe,             // drive lanes
    input  wire logic [bsz_pkg::DATA_W-1:0] data_in,             // lanes in
    input  wire logic                       port_width_ack_hi_n, // width ack 1
    input  wire logic                       port_width_ack_lo_n  // width ack 0
);

    import bsz_pkg::*;

    bsz_state_type     state_r, state_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [2:0]        rem_r, rem_nxt;
    logic [DATA_W-1:0] rem_data_r, rem_data_nxt;
    logic [DATA_W-1:0] acc_r, acc_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [DATA_W-1:0] dout_r, dout_nxt;
    logic              read_r, read_nxt;
    logic              fetch_r, fetch_nxt;
    logic              strobe_r, strobe_nxt;
    logic              oe_r, oe_nxt;
    logic              busy_r, busy_nxt;
    logic              done_r, done_nxt;
    logic [1:0]        ack_s1_r, ack_s2_r;
    logic [2:0]        pw;
    logic [2:0]        taken;
    logic [DATA_W-1:0] lane_wdata;
    logic [DATA_W-1:0] rd_bytes;

    // ************************************************************
    // width acknowledge synchroniser
    // ************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_s1_r <= ACK_RESET;
            ack_s2_r <= ACK_RESET;
        end else begin
            ack_s1_r <= {port_width_ack_hi_n, port_width_ack_lo_n};
            ack_s2_r <= ack_s1_r;
        end
    end

    assign pw    = port_bytes(ack_s2_r);
    assign taken = bytes_taken(pw, addr_r[1:0], rem_r);

    bsz_lane_steer u_steer (
        .off        (addr_r[1:0]),
        .pw         (pw),
        .taken      (taken),
        .rem_data   (rem_data_r),
        .data_in    (data_in),
        .lane_wdata (lane_wdata),
        .rd_bytes   (rd_bytes)
    );

    // ************************************************************
    // bus cycle sequencer
    // ************************************************************
    always_comb begin
        state_nxt    = state_r;
        addr_nxt     = addr_r;
        rem_nxt      = rem_r;
        rem_data_nxt = rem_data_r;
        acc_nxt      = acc_r;
        rdata_nxt    = rdata_r;
        dout_nxt     = dout_r;
        read_nxt     = read_r;
        fetch_nxt    = fetch_r;
        strobe_nxt   = strobe_r;
        oe_nxt       = oe_r;
        busy_nxt     = busy_r;
        done_nxt     = 1'b0;
        unique case (state_r)
            BSZ_IDLE: begin
                if (req) begin
                    busy_nxt  = 1'b1;
                    read_nxt  = ~req_write;
                    fetch_nxt = req_fetch;
                    acc_nxt   = '0;
                    if (req_fetch) begin
                        // fetches ignore size and offset
                        addr_nxt = {req_addr[ADDR_W-1:2], OFF_ALIGN};
                        rem_nxt  = CNT_FOUR;
                    end else begin
                        addr_nxt = req_addr;
                        rem_nxt  = size_to_count(req_size);
                    end
                    // left justify so the next byte is always on top
                    rem_data_nxt = req_wdata << {CNT_FOUR
                                   - size_to_count(req_size), 3'h0};
                    state_nxt = BSZ_ADDR;
                end
            end
            BSZ_ADDR: begin
                strobe_nxt = 1'b1;
                oe_nxt     = ~read_r;
                dout_nxt   = lane_wdata;
                state_nxt  = BSZ_DATA;
            end
            BSZ_DATA: begin
                if (ack_s2_r != ACK_NONE) begin
                    strobe_nxt   = 1'b0;
                    oe_nxt       = 1'b0;
                    acc_nxt      = (acc_r << {taken, 3'h0}) | rd_bytes;
                    rem_data_nxt = rem_data_r << {taken, 3'h0};
                    addr_nxt     = addr_r + ADDR_W'(taken);
                    rem_nxt      = rem_r - taken;
                    state_nxt    = BSZ_TERM;
                end
            end
            BSZ_TERM: begin
                // wait for the port to release its acknowledge
                if (ack_s2_r == ACK_NONE) begin
                    if (rem_r == CNT_ZERO) begin
                        busy_nxt  = 1'b0;
                        done_nxt  = 1'b1;
                        rdata_nxt = acc_r;
                        state_nxt = BSZ_IDLE;
                    end else begin
                        state_nxt = BSZ_ADDR;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r    <= BSZ_IDLE;
            addr_r     <= '0;
            rem_r      <= CNT_FOUR;
            rem_data_r <= '0;
            acc_r      <= '0;
            rdata_r    <= '0;
            dout_r     <= '0;
            read_r     <= 1'b1;
            fetch_r    <= 1'b0;
            strobe_r   <= 1'b0;
            oe_r       <= 1'b0;
            busy_r     <= 1'b0;
            done_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            addr_r     <= addr_nxt;
            rem_r      <= rem_nxt;
            rem_data_r <= rem_data_nxt;
            acc_r      <= acc_nxt;
            rdata_r    <= rdata_nxt;
            dout_r     <= dout_nxt;
            read_r     <= read_nxt;
            fetch_r    <= fetch_nxt;
            strobe_r   <= strobe_nxt;
            oe_r       <= oe_nxt;
            busy_r     <= busy_nxt;
            done_r     <= done_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign busy                = busy_r;
    assign done                = done_r;
    assign rdata               = rdata_r;
    assign bus_addr            = addr_r;
    assign xfer_size_hi        = rem_r[1];
    assign xfer_size_lo        = rem_r[0];
    assign bus_read            = read_r;
    assign addr_valid_strobe_n = ~strobe_r;
    assign data_valid_strobe_n = ~strobe_r;
    assign data_out            = dout_r;
    assign data_oe             = oe_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_size_code: assert property (
        !addr_valid_strobe_n |-> {xfer_size_hi, xfer_size_lo}
            == ((rem_r == CNT_FOUR) ? SIZE_LONG : rem_r[1:0]))
        else $error("size code does not match remaining bytes");

    chk_size_start: assert property (
        state_r == BSZ_IDLE && req && !req_fetch
            |=> {xfer_size_hi, xfer_size_lo} == $past(req_size))
        else $error("size code differs from requested size");

    chk_fetch_align: assert property (
        state_r == BSZ_IDLE && req && req_fetch |=> ##1
            !addr_valid_strobe_n && bus_addr[1:0] == OFF_ALIGN
            && {xfer_size_hi, xfer_size_lo} == SIZE_LONG)
        else $error("fetch not long-word aligned");

    chk_addr_step: assert property (
        state_r == BSZ_DATA && ack_s2_r != ACK_NONE
            |=> bus_addr == $past(bus_addr) + ADDR_W'($past(taken)))
        else $error("address did not advance by bytes moved");

    chk_split_rest: assert property (
        state_r == BSZ_DATA && ack_s2_r != ACK_NONE
            |=> rem_r == $past(rem_r) - $past(taken)
                && addr_valid_strobe_n)
        else $error("remainder not reduced after bus cycle");

    chk_top_lane: assert property (
        !addr_valid_strobe_n && data_oe
            |-> data_out[31:24] == rem_data_r[31:24])
        else $error("top lane lacks next operand byte");

    chk_odd_word16: assert property (
        state_r == BSZ_DATA && ack_s2_r == ACK_PORT16 && addr_r[0]
            |-> taken == CNT_ONE)
        else $error("odd 16-bit cycle moved more than one byte");

    chk_lane32_span: assert property (
        state_r == BSZ_DATA && ack_s2_r == ACK_PORT32
            |-> taken == ((rem_r < CNT_FOUR - {1'b0, addr_r[1:0]})
                ? rem_r : CNT_FOUR - {1'b0, addr_r[1:0]}))
        else $error("32-bit cycle byte count wrong");

    chk_lane16_odd: assert property (
        !addr_valid_strobe_n && data_oe && bus_addr[0]
            |-> data_out[23:16] == rem_data_r[31:24])
        else $error("odd 16-bit write byte not on second lane");

endmodule

// ---- verif/bsz_port_model.sv ----
module bsz_port_model (
    input  wire logic                       clk,       // bus clock
    input  wire logic                       nrst,      // reset, active low
    input  wire logic [1:0]                 ack_code,  // width reply {hi, lo}
    input  wire logic [3:0]                 wait_cyc,  // cycles before reply
    input  wire logic [bsz_pkg::ADDR_W-1:0] bus_addr,  // address pins
    input  wire logic [1:0]                 size_code, // remaining bytes code
    input  wire logic                       bus_read,  // 1 read, 0 write
    input  wire logic                       as_n,      // address strobe
    input  wire logic                       cpu_space, // processor space
    input  wire logic [bsz_pkg::DATA_W-1:0] data_out,  // write lanes
    output logic      [bsz_pkg::DATA_W-1:0] data_in,   // read lanes
    output logic                            ack_hi_n,  // width ack hi
    output logic                            ack_lo_n   // width ack lo
);
    timeunit 1ns;
    timeprecision 1ns;
    import bsz_pkg::*;
    // ************************************************************
    // port of 8, 16 or 32 bits with its own lane decode
    // ************************************************************
    logic [7:0] mem [256];
    logic [3:0] cnt;
    logic [7:0] a;
    int         pw;
    int         base;
    int         nb;

    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;

    // everything qualified by the address strobe, nothing latched
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {ack_hi_n, ack_lo_n} <= ACK_NONE;
            cnt <= 4'h0;
            data_in <= 32'h0f0f_0f0f;
        end else if (as_n) begin
            {ack_hi_n, ack_lo_n} <= ACK_NONE;
            cnt <= 4'h0;
            data_in <= ~data_in; // released bus must not look valid
        end else if ({ack_hi_n, ack_lo_n} == ACK_NONE) begin
            if (cnt < wait_cyc) begin
                cnt <= cnt + 4'h1;
            end else begin
                pw = (ack_code == ACK_PORT32) ? 4 :
                     (ack_code == ACK_PORT16) ? 2 : 1;
                base = int'(bus_addr[1:0]) % pw;
                nb = (size_code == 2'h0) ? 4 : int'(size_code);
                if (nb > pw - base) nb = pw - base;
                for (int k = 0; k < 4; k++) begin
                    a = bus_addr[7:0] - 8'(base) + 8'(k);
                    // processor-space writes never reach mapped lanes; reads still return mapped bytes
                    if (!bus_read && !cpu_space && k >= base
                        && k < base + nb) begin
                        mem[a] = data_out[31-8*k -: 8];
                    end
                    if (bus_read) begin
                        data_in[31-8*k -: 8] <= (k < pw) ? mem[a] :
                            ~data_in[31-8*k -: 8];
                    end
                end
                {ack_hi_n, ack_lo_n} <= ack_code;
            end
        end
    end
endmodule

// ---- verif/tb_byte_lane_select_decoder.sv ----
module tb_byte_lane_select_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    import bsz_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, req = 1'b0, req_write = 1'b0;
    logic        req_fetch = 1'b0, busy, done, xs_hi, xs_lo, bus_read;
    logic        as_n, ds_n, data_oe, ack_hi_n, ack_lo_n;
    logic        cpu_space = 1'b0;
    logic [1:0]  req_size = 2'h0, ack_code = ACK_PORT32;
    logic [3:0]  wait_cyc = 4'h0;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rdata, bus_addr;
    logic [31:0] data_out, data_in, seed = 32'h6194_47dd;
    logic [7:0]  exp_mem [256];
    int          miscompares = 0, checked = 0, ticks = 0;
    logic [1:0]  widths [3] = '{ACK_PORT32, ACK_PORT16, ACK_PORT8};

    always #25 clk = ~clk;

    bsz_bus_sizer DUT (.clk(clk), .nrst(nrst), .req(req),
        .req_write(req_write), .req_fetch(req_fetch), .req_size(req_size),
        .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
        .done(done), .rdata(rdata), .bus_addr(bus_addr),
        .xfer_size_hi(xs_hi), .xfer_size_lo(xs_lo), .bus_read(bus_read),
        .addr_valid_strobe_n(as_n), .data_valid_strobe_n(ds_n),
        .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
        .port_width_ack_hi_n(ack_hi_n), .port_width_ack_lo_n(ack_lo_n));

    bsz_port_model PORT (.clk(clk), .nrst(nrst), .ack_code(ack_code),
        .wait_cyc(wait_cyc), .bus_addr(bus_addr), .size_code({xs_hi, xs_lo}),
        .bus_read(bus_read), .as_n(as_n), .cpu_space(cpu_space),
        .data_out(data_out), .data_in(data_in), .ack_hi_n(ack_hi_n),
        .ack_lo_n(ack_lo_n));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk_word(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, exp, input string what);
        checked++;
        if (got != exp) begin
            miscompares++;
            $display("unexpected at %0t: %s %0d not %0d", $time, what,
                     got, exp);
        end
    endtask

    task automatic finish_test;
        $display("compares %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // whole operand, cycles tracked against the remainder MSB first
    task automatic xfer(input logic w, f, input logic [1:0] sz,
                        input logic [31:0] ad, wd, input logic poke);
        int          n, rem, cyc, pw, room, t, guard;
        logic [31:0] ea, a0, er;
        logic        prev;
        n = (f || sz == 2'h0) ? 4 : int'(sz);
        a0 = f ? {ad[31:2], 2'h0} : ad;
        pw = (ack_code == ACK_PORT32) ? 4 : (ack_code == ACK_PORT16) ? 2 : 1;
        er = 32'h0;
        for (int i = 0; i < n; i++) begin
            if (w && !cpu_space) exp_mem[8'(a0 + 32'(i))] = wd[8*(n-1-i) +: 8];
            er = {er[23:0], exp_mem[8'(a0 + 32'(i))]};
        end
        req = 1'b1; req_write = w; req_fetch = f; req_size = sz;
        req_addr = ad; req_wdata = wd;
        ea = a0; rem = n; cyc = 0; prev = 1'b1; guard = 0;
        @(negedge clk);
        while (done !== 1'b1 && guard < 600) begin
            req = 1'b0;
            if (prev === 1'b1 && as_n === 1'b0) begin
                cyc++;
                chk_word(bus_addr, ea, "address");
                chk_word({30'h0, xs_hi, xs_lo}, 32'(rem % 4), "size");
                chk_word({31'h0, bus_read}, {31'h0, !w}, "dir");
                chk_word({29'h0, busy, ds_n, data_oe}, {29'h0, 2'h2, w},
                         "strobes");
                room = (pw == 4) ? 4 - int'(ea[1:0]) :
                       (pw == 2) ? 2 - int'(ea[0]) : 1;
                t = (rem < room) ? rem : room;
                ea = ea + 32'(t);
                rem = rem - t;
                if (poke && cyc == 1) begin
                    req = 1'b1; req_write = 1'b1; req_addr = ~ad;
                end
            end
            prev = as_n;
            @(negedge clk);
            guard++;
        end
        req = 1'b0;
        chk_cnt(rem, 0, "bytes left at end");
        chk_word({30'h0, done, busy}, 32'h2, "done");
        if (!w) chk_word(rdata, er, "read operand");
        @(negedge clk);
        chk_word({31'h0, done}, 32'h0, "done pulse");
    endtask

    always @(posedge clk) begin
        ticks++;
        if (ticks == 80000) begin
            miscompares++;
            $display("unexpected at %0t: run too long", $time);
            finish_test();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        for (int i = 0; i < 256; i++) exp_mem[i] = 8'(i) ^ 8'h5a;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        // every width, size code and offset, write then read back
        for (int p = 0; p < 3; p++) begin
            for (int s = 0; s < 4; s++) begin
                for (int o = 0; o < 4; o++) begin
                    ack_code = widths[p];
                    wait_cyc = 4'(o);
                    seed = lfsr(seed);
                    xfer(1'b1, 1'b0, 2'(s), 32'(64 + 16 * s + o), seed,
                         1'b0);
                    xfer(1'b0, 1'b0, 2'(s), 32'(64 + 16 * s + o), 32'h0,
                         1'b0);
                end
            end
        end
        $display("test corner done");
        for (int o = 0; o < 4; o++) begin
            ack_code = widths[o % 3];
            xfer(1'b0, 1'b1, 2'(o), 32'(o + 9), 32'h0, 1'b0);
        end
        $display("test fetch done");
        // a processor-space write must leave the mapped bytes alone
        cpu_space = 1'b1;
        ack_code = ACK_PORT32;
        seed = lfsr(seed);
        xfer(1'b1, 1'b0, 2'h0, 32'h0000_0044, seed, 1'b0);
        cpu_space = 1'b0;
        xfer(1'b0, 1'b0, 2'h0, 32'h0000_0044, 32'h0, 1'b0);
        $display("test space done");
        for (int r = 0; r < 150; r++) begin
            seed = lfsr(seed);
            ack_code = widths[seed[1:0] % 3];
            wait_cyc = {2'h0, seed[3:2]};
            xfer(seed[4], 1'b0, seed[6:5], {seed[31:24], 16'h0, seed[15:8]},
                 lfsr(seed), seed[7]);
        end
        $display("test random done");
        wait_cyc = 4'h8;
        req = 1'b1; req_write = 1'b1; req_size = 2'h0;
        @(negedge clk);
        req = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b0;
        @(negedge clk);
        chk_word({30'h0, busy, as_n}, 32'h1, "reset outputs");
        nrst = 1'b1;
        @(negedge clk);
        xfer(1'b0, 1'b0, 2'h0, 32'h0000_0003, 32'h0, 1'b0);
        $display("test reset done");
        finish_test();
    end
endmodule
